/* File: bench/ctrl_model.sv */
module ctrl_model (
  input  wire logic       clock,
  input  wire logic [2:0] op,
  output logic            cke,
  output logic [3:0]      cmd,
  output logic            ck,
  output logic            ck_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic flip;
  initial
  begin
    flip = 1'h0;
    cke = 1'h1;
    cmd = lpdram_sleep_pkg::cmd_nop;
    ck = 1'h0;
    ck_n = 1'h1;
  end
  // Clock keeps running at one rate except in ops 4 and 5
  always @(negedge clock)
  begin
    flip <= ~flip;
    ck <= (op == 3'h4) ? 1'h0 : (op == 3'h5) ? 1'h1 : ~ck;
    ck_n <= (op == 3'h4) ? 1'h1 : (op == 3'h5) ? 1'h0 : ck;
    cke <= !(op == 3'h1 || op == 3'h2);
    case (op)
      3'h1, 3'h7: cmd <= lpdram_sleep_pkg::cmd_sleep;
      3'h2: cmd <= {4{flip}}; // Junk while asleep
      3'h6: cmd <= 4'h3;
      default: cmd <= lpdram_sleep_pkg::cmd_nop;
    endcase
  end
endmodule

/* File: bench/lpdram_deep_sleep_clock_stop_tb.sv */
module lpdram_deep_sleep_clock_stop_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clock = 1'h0;
  logic       srst = 1'h1;
  logic       init_done = 1'h0;
  logic [2:0] op = 3'h0;
  logic       cke, ck, ck_n;
  logic [3:0] cmd;
  logic [5:0] st;
  int         failures = 0;
  int         n_compared = 0;
  int         cycles = 0;
  ctrl_model model (.clock(clock), .op(op), .cke(cke), .cmd(cmd), .ck(ck),
    .ck_n(ck_n));
  lpdram_deep_sleep_clock_stop DUT (.clock(clock), .srst(srst),
    .clock_enable_pin(cke), .chip_select_n(cmd[3]), .row_strobe_n(cmd[2]),
    .column_strobe_n(cmd[1]), .write_enable_n(cmd[0]), .true_clock(ck),
    .clock_complement(ck_n), .init_done(init_done),
    .in_deep_sleep(st[5]), .array_powered(st[4]), .contents_valid(st[3]),
    .commands_enabled(st[2]), .clock_stopped(st[1]),
    .protocol_error(st[0]));
  initial forever #5 clock = ~clock;
  // Whole run is near 100 cycles, so 2000 only trips on a hang
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      failures++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [5:0] seen, input logic [5:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // Waits cover the 3-edge pin-to-output latency with margin
  task automatic go(input logic [2:0] o, input int n);
    op <= o;
    repeat (n) @(negedge clock);
  endtask
  task automatic t_reset();
    srst <= 1'h1;
    go(3'h0, 4);
    srst <= 1'h0;
    go(3'h0, 2);
    check(st, 6'h1c);
  endtask
  task automatic t_sleep();
    go(3'h1, 1);
    go(3'h2, 6);
    check(st, 6'h20);
    go(3'h2, 10);
    check(st, 6'h20);
    go(3'h6, 8);
    check(st, 6'h20);
    go(3'h3, 6);
    check(st, 6'h10);
    init_done <= 1'h1;
    go(3'h0, 1);
    init_done <= 1'h0;
    go(3'h0, 3);
    check(st, 6'h1c);
  endtask
  task automatic t_no_sleep();
    go(3'h7, 1);
    go(3'h0, 6);
    check(st, 6'h1c);
  endtask
  task automatic t_stop();
    go(3'h4, 6);
    check(st, 6'h1a);
    go(3'h0, 6);
    check(st, 6'h1c);
    go(3'h5, 6);
    check({5'h0, st[0]}, 6'h01);
    t_reset();
  endtask
  // Valid command right on restart must be flagged
  task automatic t_early_cmd();
    go(3'h4, 6);
    check(st, 6'h1a);
    go(3'h6, 6);
    check(st, 6'h1d);
    t_reset();
  endtask
  initial
  begin
    t_reset();
    t_sleep();
    t_no_sleep();
    t_stop();
    t_early_cmd();
    wrap_up();
  end
endmodule

/* File: hdl/lpdram_deep_sleep_clock_stop.sv */
// Summary of operation
// - Entry decodes select and write low, strobes high, clock enable low.
// - The device stays in deep sleep while clock enable is low, and with clock enable high until a NOP or DESELECT.
// - Deep sleep ends on clock enable high with a NOP or DESELECT command.
// - Deep sleep removes array power, so stored contents are lost.
module lpdram_deep_sleep_clock_stop (
  input  wire logic clock,
  input  wire logic srst,
  input  wire logic clock_enable_pin,
  input  wire logic chip_select_n,
  input  wire logic row_strobe_n,
  input  wire logic column_strobe_n,
  input  wire logic write_enable_n,
  input  wire logic true_clock,
  input  wire logic clock_complement,
  input  wire logic init_done,
  output logic      in_deep_sleep,
  output logic      array_powered,
  output logic      contents_valid,
  output logic      commands_enabled,
  output logic      clock_stopped,
  output logic      protocol_error
);
  logic [6:0] pins;
  logic       cke;
  logic       cs_n;
  logic       ras_n;
  logic       cas_n;
  logic       we_n;
  logic       ck_t;
  logic       ck_c;
  logic       ck_t_prev;
  logic       guard_cycle;
  logic [1:0] warmup;
  lpdram_sleep_pkg::power_e state;
  lpdram_sleep_pkg::power_e next_state;

  // Pins come from the controller's domain, so all are synchronised
  pin_sync #(
    .width    (7)
  ) u_sync (
    .clock    (clock),
    .srst     (srst),
    .async_in ({clock_enable_pin, chip_select_n, row_strobe_n,
                column_strobe_n, write_enable_n, true_clock,
                clock_complement}),
    .sync_out (pins)
  );

  assign {cke, cs_n, ras_n, cas_n, we_n, ck_t, ck_c} = pins;

  wire logic [3:0] cmd = {cs_n, ras_n, cas_n, we_n};
  wire logic sleep_cmd = (cmd == lpdram_sleep_pkg::cmd_sleep) &&
                         !cke;
  wire logic nop_or_desel = (cs_n == lpdram_sleep_pkg::deselect_cs) ||
                            (cmd == lpdram_sleep_pkg::cmd_nop);
  wire logic wake = cke && nop_or_desel;
  wire logic primed = warmup == lpdram_sleep_pkg::settle_count;
  wire logic halt_seen = primed && (ck_t == ck_t_prev);
  wire logic halt_legal = cke && !ck_t && ck_c;
  wire logic valid_cmd = cke && !nop_or_desel;

  // Sync stages hold reset zeros for a few edges, so a held level then
  // is no real clock stop; halt detection waits until they settle
  always_ff @(posedge clock)
  begin
    if (srst)
      warmup <= 2'h0;
    else if (!primed)
      warmup <= warmup + 2'h1;
  end

  always_comb
  begin
    next_state = state;
    unique case (state)
      lpdram_sleep_pkg::st_run:
        if (sleep_cmd)
          next_state = lpdram_sleep_pkg::st_deep_sleep;
        else if (halt_seen && halt_legal)
          next_state = lpdram_sleep_pkg::st_clock_stopped;
      lpdram_sleep_pkg::st_deep_sleep:
        // Only clock enable and the NOP or DESELECT decode matter here
        if (wake)
          next_state = lpdram_sleep_pkg::st_need_init;
        else if (cke)
          next_state = lpdram_sleep_pkg::st_deep_sleep;
      lpdram_sleep_pkg::st_need_init:
        if (init_done)
          next_state = lpdram_sleep_pkg::st_run;
      lpdram_sleep_pkg::st_clock_stopped:
        if (!halt_seen)
          next_state = lpdram_sleep_pkg::st_run;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      state       <= lpdram_sleep_pkg::st_run;
      ck_t_prev   <= lpdram_sleep_pkg::pin_reset_val;
      guard_cycle <= 1'h0;
    end
    else
    begin
      state     <= next_state;
      ck_t_prev <= ck_t;
      // One guard cycle after restart
      guard_cycle <= (state == lpdram_sleep_pkg::st_clock_stopped) &&
                     (next_state == lpdram_sleep_pkg::st_run);
    end
  end

  // Contents lost on entry; only a full init restores validity.
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      in_deep_sleep    <= 1'h0;
      array_powered    <= 1'h1;
      contents_valid   <= 1'h1;
      commands_enabled <= 1'h1;
      clock_stopped    <= 1'h0;
      protocol_error   <= 1'h0;
    end
    else
    begin
      in_deep_sleep  <= next_state == lpdram_sleep_pkg::st_deep_sleep;
      array_powered  <= next_state != lpdram_sleep_pkg::st_deep_sleep;
      clock_stopped  <= next_state == lpdram_sleep_pkg::st_clock_stopped;
      commands_enabled <= next_state == lpdram_sleep_pkg::st_run;
      if (next_state == lpdram_sleep_pkg::st_deep_sleep)
        contents_valid <= 1'h0;
      else if (state == lpdram_sleep_pkg::st_need_init && init_done)
        contents_valid <= 1'h1;
      // Sticky until reset: a valid command right after restart.
      if (guard_cycle && valid_cmd)
        protocol_error <= 1'h1;
      // Clock held with wrong levels while clock enable is high.
      if (state == lpdram_sleep_pkg::st_run && halt_seen && !halt_legal
          && cke)
        protocol_error <= 1'h1;
    end
  end

  a_entry_decode:
    assert property (@(posedge clock) disable iff (srst)
      (state == lpdram_sleep_pkg::st_run && sleep_cmd) |=> in_deep_sleep)
    else $error("deep sleep entry missed");
  a_stay_low:
    assert property (@(posedge clock) disable iff (srst)
      (state == lpdram_sleep_pkg::st_deep_sleep && !cke) |=> in_deep_sleep)
    else $error("left deep sleep with clock enable low");
  a_exit_wake:
    assert property (@(posedge clock) disable iff (srst)
      (state == lpdram_sleep_pkg::st_deep_sleep && wake) |=>
      (!in_deep_sleep && !commands_enabled))
    else $error("deep sleep exit wrong");
  a_stay_no_nop:
    assert property (@(posedge clock) disable iff (srst)
      (state == lpdram_sleep_pkg::st_deep_sleep && cke && !nop_or_desel)
      |=> in_deep_sleep)
    else $error("deep sleep left without a NOP");
  a_data_lost:
    assert property (@(posedge clock) disable iff (srst)
      $rose(in_deep_sleep) |-> (!contents_valid && !array_powered))
    else $error("contents kept across deep sleep");
  a_init_needed:
    assert property (@(posedge clock) disable iff (srst)
      $fell(in_deep_sleep) |-> (!commands_enabled)[*2])
    else $error("commands enabled without init");
  a_init_wait:
    assert property (@(posedge clock) disable iff (srst)
      (state == lpdram_sleep_pkg::st_need_init && !init_done) |=>
      !commands_enabled)
    else $error("commands enabled before init done");
  a_init_restore:
    assert property (@(posedge clock) disable iff (srst)
      (state == lpdram_sleep_pkg::st_need_init && init_done) |=>
      (commands_enabled && contents_valid))
    else $error("init done did not restore operation");
  a_ignore_cmds:
    assert property (@(posedge clock) disable iff (srst)
      in_deep_sleep |-> !commands_enabled)
    else $error("commands accepted in deep sleep");
  a_junk_ignored:
    assert property (@(posedge clock) disable iff (srst)
      (state == lpdram_sleep_pkg::st_deep_sleep && !cke) |=>
      (!commands_enabled && !array_powered))
    else $error("activity while in deep sleep");
  a_sleep_no_stop:
    assert property (@(posedge clock) disable iff (srst)
      in_deep_sleep |-> !clock_stopped)
    else $error("clock stop reported in deep sleep");
  a_stop_levels:
    assert property (@(posedge clock) disable iff (srst)
      $rose(clock_stopped) |-> $past(halt_legal))
    else $error("clock stop with wrong levels");
  a_stop_enter:
    assert property (@(posedge clock) disable iff (srst)
      (state == lpdram_sleep_pkg::st_run && halt_seen && halt_legal) |=>
      clock_stopped)
    else $error("legal clock stop missed");
  a_bad_halt:
    assert property (@(posedge clock) disable iff (srst)
      (state == lpdram_sleep_pkg::st_run && halt_seen && !halt_legal &&
       cke) |=> protocol_error)
    else $error("illegal clock hold not flagged");
  a_restart_guard:
    assert property (@(posedge clock) disable iff (srst)
      (guard_cycle && valid_cmd) |=> protocol_error)
    else $error("early command not flagged");
  a_restart_exit:
    assert property (@(posedge clock) disable iff (srst)
      (state == lpdram_sleep_pkg::st_clock_stopped && !halt_seen) |=>
      (commands_enabled && !clock_stopped))
    else $error("clock restart not taken");
endmodule

/* File: hdl/lpdram_sleep_pkg.sv */
package lpdram_sleep_pkg;
  // Command bus encoding {cs_n, ras_n, cas_n, we_n}
  localparam logic [3:0] cmd_nop        = 4'h7;
  localparam logic [3:0] cmd_sleep      = 4'h6;
  localparam logic       deselect_cs    = 1'h1;
  localparam logic       pin_reset_val  = 1'h0;
  // Edges until sync stages and previous clock sample hold real values
  localparam logic [1:0] settle_count   = 2'h3;
  typedef enum logic [1:0] {
    st_run,
    st_deep_sleep,
    st_need_init,
    st_clock_stopped
  } power_e;
endpackage

/* File: hdl/pin_sync.sv */
module pin_sync #(
  parameter int width = 1
) (
  input  wire logic             clock,
  input  wire logic             srst,
  input  wire logic [width-1:0] async_in,
  output logic      [width-1:0] sync_out
);
  logic [width-1:0] stage1;

  // Elaboration check
  if (width < 1)
    $error("pin_sync width must be at least one");

  // First stage is read only by the second
  always_ff @(posedge clock)
  begin
    if (srst)
    begin
      stage1   <= '0;
      sync_out <= '0;
    end
    else
    begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule
